// *** logic/host_port_map.svh ***
// Offsets, field positions, reset values and address windows of the host port
// Operation
// - The host sees a 768 Kbyte instruction RAM mirror whose real target depends on the boot pins.
// - With both boot pins low the host port is off and the mirror has no target.
// - With high pin low and low pin high the mirror is reserved and host accesses to it are refused.
// - With the high boot pin set, mirror accesses go to the instruction RAM whatever the low pin is.
// - The network controller window is open only in the synchronous SRAM connection mode.
// - The upper 52 Kbytes of the peripheral register area are mapped into host space.
// - Bit 1 of the host bus control register turns advance reading of the mirror off (0) or on (1).
// - The mirror spans host 00 0000H to 0B FFFFH, internal 0000 0000H to 000B FFFFH.
// - Advance reading is chosen by the bus control bit and page reading by the page control bit.
// - Bit 1 of the page ROM control register picks SRAM reading (0) or page ROM reading (1).
// - A read of the last 16 bytes of the mirror with advance reading on drives the host error pin.
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define REG_BUS_CTRL 8'h00
`define REG_PAGE_CTRL 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_PORT_STATUS 8'h10

`define PREFETCH_EN_BIT 1
`define PAGE_SEL_BIT 1

`define IRQ_REFUSED_BIT 0
`define IRQ_TAIL_BIT 1
`define IRQ_W 2

`define ST_BOOT_LOW_BIT 0
`define ST_BOOT_HIGH_BIT 1
`define ST_SYNC_MODE_BIT 2
`define ST_BUSY_BIT 3
`define ST_BUF_VALID_BIT 4

`define CTRL_RESET 1'h0
`define PAGE_RESET 1'h0
`define IRQ_RESET 2'h0

`define MIRROR_SIZE 24'h0C0000
`define MIRROR_TAIL 24'h0BFFF0
`define MIRROR_WORDS 22'h030000
`define IRAM_INT_BASE 32'h00000000
`define PERI_SIZE 24'h00D000

`endif

// *** logic/host_port_pkg.sv ***
// Types shared by the host port files
package host_port_pkg;
  typedef enum logic [1:0] {
    TGT_IRAM,
    TGT_PERI,
    TGT_NET
  } target_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_RESPOND,
    ST_PREFETCH
  } state_t;
endpackage

// *** logic/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_q <= meta_q;
    end
  end

  assign q_o = q_q;
endmodule // pin_sync

// *** logic/prefetch_buf.sv ***
// One-word advance read buffer for the mirror
`timescale 1ns/10ps
module prefetch_buf #(
  parameter int AW = 22,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill and flush
  input wire logic load_i,
  input wire logic flush_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] data_i,
  // Contents
  output logic valid_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] data_o
);
  logic valid_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;

  // Load wins over flush
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else if (load_i) begin
      valid_q <= 1'b1;
    end else if (flush_i) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      data_q <= '0;
    end else if (load_i) begin
      addr_q <= addr_i;
      data_q <= data_i;
    end
  end

  assign valid_o = valid_q;
  assign addr_o = addr_q;
  assign data_o = data_q;
endmodule // prefetch_buf

// *** logic/host_port_mirror_read.sv ***
// Host port decode, boot-mode routing and mirror advance reading
`timescale 1ns/10ps
`include "host_port_map.svh"
module host_port_mirror_read #(
  parameter logic [23:0] PERI_HOST_BASE = 24'h0C0000,
  parameter logic [31:0] PERI_INT_BASE = 32'h40000000,
  parameter logic [23:0] NET_HOST_BASE = 24'h100000,
  parameter logic [23:0] NET_SIZE = 24'h100000,
  parameter logic [31:0] NET_INT_BASE = 32'h50000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Strap and mode pins
  input wire logic boot_select_high_i,
  input wire logic boot_select_low_i,
  input wire logic sync_sram_mode_i,
  // External processor port pins
  input wire logic chip_select_n_i,
  input wire logic host_rd_n_i,
  input wire logic host_wr_n_i,
  input wire logic [23:0] host_addr_i,
  input wire logic [31:0] host_data_i,
  output logic [31:0] host_data_o,
  output logic host_data_oe_o,
  output logic host_ready_o,
  output logic host_error_out_n_o,
  // Internal bus master
  output logic mem_req_o,
  output logic mem_we_o,
  output host_port_pkg::target_t mem_target_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_page_read_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i
);
  localparam int PIN_W = 62;

  if (PERI_HOST_BASE < `MIRROR_SIZE) begin : g_bad_peri
    $error("Peripheral window overlaps the mirror");
  end
  if (NET_SIZE == 24'h000000) begin : g_bad_net
    $error("Network window size must be non-zero");
  end

  // Synchronised pins
  logic [PIN_W-1:0] pins_s;
  logic boot_hi_s;
  logic boot_lo_s;
  logic sync_mode_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [23:0] addr_s;
  logic [31:0] wdat_s;

  pin_sync #(
    .W(PIN_W),
    .RST_VAL({3'h0, 3'h7, 56'h0})
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({boot_select_high_i, boot_select_low_i, sync_sram_mode_i, chip_select_n_i, host_rd_n_i,
          host_wr_n_i, host_addr_i, host_data_i}),
    .q_o(pins_s)
  );

  assign {boot_hi_s, boot_lo_s, sync_mode_s, cs_n_s, rd_n_s, wr_n_s, addr_s, wdat_s} = pins_s;

  // Registers
  logic ctrl_pf_q;
  logic page_sel_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;

  // State
  host_port_pkg::state_t state_q;
  host_port_pkg::state_t state_d;
  logic err_q;
  logic [31:0] rdata_q;
  logic pf_want_q;
  logic [21:0] pf_word_q;
  logic rd_q;
  logic mem_we_q;
  host_port_pkg::target_t mem_target_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  logic mem_page_q;

  // Buffer
  logic buf_valid;
  logic [21:0] buf_addr;
  logic [31:0] buf_data;
  logic buf_load;
  logic buf_flush;

  // Host strobes
  wire host_rd = ~cs_n_s & ~rd_n_s;
  wire host_wr = ~cs_n_s & ~wr_n_s & rd_n_s;
  wire host_active = host_rd | host_wr;

  // Boot-mode routing
  wire port_on = boot_hi_s | boot_lo_s;
  wire mirror_ok = boot_hi_s;

  // Address windows
  wire in_mirror = addr_s < `MIRROR_SIZE;
  wire [23:0] peri_off = addr_s - PERI_HOST_BASE;
  wire [23:0] net_off = addr_s - NET_HOST_BASE;
  wire in_peri = (addr_s >= PERI_HOST_BASE) & (peri_off < `PERI_SIZE);
  wire in_net = (addr_s >= NET_HOST_BASE) & (net_off < NET_SIZE);
  wire net_ok = sync_mode_s;
  wire unmapped = ~in_mirror & ~in_peri & ~in_net;
  wire refuse = (in_mirror & ~mirror_ok) | (in_net & ~net_ok) | unmapped;

  // Advance reading decisions
  wire pf_en = ctrl_pf_q;
  wire tail_hit = in_mirror & mirror_ok & host_rd & pf_en & (addr_s >= `MIRROR_TAIL);
  wire buf_hit = pf_en & buf_valid & (buf_addr == addr_s[23:2]) & in_mirror & mirror_ok & host_rd;
  wire [21:0] next_word = addr_s[23:2] + 22'h000001;
  wire next_ok = next_word < `MIRROR_WORDS;

  wire go = (state_q == host_port_pkg::ST_IDLE) & port_on & host_active;
  wire go_refuse = go & (refuse | tail_hit);
  wire go_hit = go & ~refuse & ~tail_hit & buf_hit;
  wire go_fetch = go & ~refuse & ~tail_hit & ~buf_hit;

  // Target address
  wire host_port_pkg::target_t tgt_sel = in_mirror ? host_port_pkg::TGT_IRAM :
                                         in_peri ? host_port_pkg::TGT_PERI : host_port_pkg::TGT_NET;
  wire [31:0] int_addr = in_mirror ? (`IRAM_INT_BASE | {8'h00, addr_s}) :
                         in_peri ? (PERI_INT_BASE + {8'h00, peri_off}) :
                         (NET_INT_BASE + {8'h00, net_off});

  // Events
  wire ev_refused = go & refuse;
  wire ev_tail = go & ~refuse & tail_hit;
  wire [`IRQ_W-1:0] ev_vec = {ev_tail, ev_refused};

  // Host release after an answer
  wire released = (state_q == host_port_pkg::ST_RESPOND) & ~host_active;

  always_comb begin
    state_d = state_q;
    case (state_q)
      host_port_pkg::ST_IDLE: begin
        if (go_fetch) begin
          state_d = host_port_pkg::ST_FETCH;
        end else if (go) begin
          state_d = host_port_pkg::ST_RESPOND;
        end
      end
      host_port_pkg::ST_FETCH: begin
        if (mem_ack_i) begin
          state_d = host_port_pkg::ST_RESPOND;
        end
      end
      host_port_pkg::ST_RESPOND: begin
        if (~host_active) begin
          state_d = (pf_want_q & pf_en) ? host_port_pkg::ST_PREFETCH : host_port_pkg::ST_IDLE;
        end
      end
      host_port_pkg::ST_PREFETCH: begin
        if (mem_ack_i) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= host_port_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      rd_q <= 1'b0;
      rdata_q <= 32'h00000000;
      mem_we_q <= 1'b0;
      mem_target_q <= host_port_pkg::TGT_IRAM;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 32'h00000000;
      mem_page_q <= 1'b0;
    end else if (go) begin
      err_q <= refuse | tail_hit;
      rd_q <= host_rd;
      rdata_q <= buf_hit ? buf_data : 32'h00000000;
      mem_we_q <= host_wr;
      mem_target_q <= tgt_sel;
      mem_addr_q <= int_addr;
      mem_wdata_q <= wdat_s;
      mem_page_q <= page_sel_q & in_mirror & host_rd;
    end else if (state_q == host_port_pkg::ST_FETCH && mem_ack_i) begin
      rdata_q <= mem_we_q ? 32'h00000000 : mem_rdata_i;
    end else if (released && pf_want_q && pf_en) begin
      mem_we_q <= 1'b0;
      mem_target_q <= host_port_pkg::TGT_IRAM;
      mem_addr_q <= `IRAM_INT_BASE | {8'h00, pf_word_q, 2'h0};
      mem_page_q <= page_sel_q;
    end
  end

  // Prefetch request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_want_q <= 1'b0;
      pf_word_q <= 22'h000000;
    end else if (go) begin
      pf_want_q <= pf_en & in_mirror & mirror_ok & host_rd & ~refuse & ~tail_hit & next_ok;
      pf_word_q <= next_word;
    end else if (released) begin
      pf_want_q <= 1'b0;
    end
  end

  assign buf_load = (state_q == host_port_pkg::ST_PREFETCH) & mem_ack_i;
  assign buf_flush = ~pf_en | (go & host_wr & in_mirror);

  prefetch_buf #(
    .AW(22),
    .DW(32)
  ) u_prefetch_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(buf_load),
    .flush_i(buf_flush),
    .addr_i(mem_addr_q[23:2]),
    .data_i(mem_rdata_i),
    .valid_o(buf_valid),
    .addr_o(buf_addr),
    .data_o(buf_data)
  );

  // Host and internal outputs
  assign host_ready_o = state_q == host_port_pkg::ST_RESPOND;
  assign host_data_oe_o = host_ready_o & rd_q;
  assign host_data_o = rdata_q;
  assign host_error_out_n_o = ~(host_ready_o & err_q);
  assign mem_req_o = (state_q == host_port_pkg::ST_FETCH) | (state_q == host_port_pkg::ST_PREFETCH);
  assign mem_we_o = mem_we_q;
  assign mem_target_o = mem_target_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;
  assign mem_page_read_o = mem_page_q;

  // Register decode
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire wb_wr0 = wb_hit & wb_we_i & wb_sel_i[0];
  wire sel_ctrl = wb_adr_i == `REG_BUS_CTRL;
  wire sel_page = wb_adr_i == `REG_PAGE_CTRL;
  wire sel_stat = wb_adr_i == `REG_IRQ_STATUS;
  wire sel_mask = wb_adr_i == `REG_IRQ_MASK;
  wire sel_port = wb_adr_i == `REG_PORT_STATUS;
  wire [`IRQ_W-1:0] irq_clr = (wb_wr0 & sel_stat) ? wb_dat_i[`IRQ_W-1:0] : '0;
  wire [31:0] port_status = {27'h0000000, buf_valid, state_q != host_port_pkg::ST_IDLE, sync_mode_s,
                             boot_hi_s, boot_lo_s};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) begin
      rd_mux[`PREFETCH_EN_BIT] = ctrl_pf_q;
    end else if (sel_page) begin
      rd_mux[`PAGE_SEL_BIT] = page_sel_q;
    end else if (sel_stat) begin
      rd_mux[`IRQ_W-1:0] = irq_stat_q;
    end else if (sel_mask) begin
      rd_mux[`IRQ_W-1:0] = irq_mask_q;
    end else if (sel_port) begin
      rd_mux = port_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_pf_q <= `CTRL_RESET;
      page_sel_q <= `PAGE_RESET;
      irq_mask_q <= `IRQ_RESET;
    end else if (wb_wr0) begin
      if (sel_ctrl) begin
        ctrl_pf_q <= wb_dat_i[`PREFETCH_EN_BIT];
      end
      if (sel_page) begin
        page_sel_q <= wb_dat_i[`PAGE_SEL_BIT];
      end
      if (sel_mask) begin
        irq_mask_q <= wb_dat_i[`IRQ_W-1:0];
      end
    end
  end

  // Set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= `IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | ev_vec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else begin
      wb_ack_q <= wb_hit;
      wb_dat_q <= (wb_hit & ~wb_we_i) ? rd_mux : 32'h00000000;
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  port_off_quiet_a: assert property ((state_q == host_port_pkg::ST_IDLE && !port_on) |=>
    (state_q == host_port_pkg::ST_IDLE) && host_ready_o == 1'b0) else $error("Port answered while disabled");
  reserved_refused_a: assert property ((go && in_mirror && !boot_hi_s) |=>
    host_ready_o && !host_error_out_n_o && !mem_req_o) else $error("Reserved mirror not refused");
  mirror_to_iram_a: assert property ((go_fetch && in_mirror) |=>
    mem_req_o && mem_target_o == host_port_pkg::TGT_IRAM && mem_addr_o == {8'h00, $past(addr_s)})
    else $error("Mirror access misrouted");
  net_needs_sync_a: assert property ((go && in_net && !sync_mode_s) |=>
    err_q && !mem_req_o) else $error("Network window open outside sync mode");
  peri_slice_map_a: assert property ((go_fetch && in_peri) |=>
    mem_target_o == host_port_pkg::TGT_PERI && mem_addr_o == PERI_INT_BASE + {8'h00, $past(peri_off)})
    else $error("Peripheral slice misrouted");
  prefetch_next_a: assert property ((released && pf_want_q && pf_en) |=>
    state_q == host_port_pkg::ST_PREFETCH && mem_addr_o[23:2] == $past(pf_word_q))
    else $error("Advance read missing or wrong");
  prefetch_off_a: assert property ((released && !pf_en) |=>
    state_q != host_port_pkg::ST_PREFETCH) else $error("Advance read while disabled");
  page_scope_a: assert property ((mem_req_o && mem_page_read_o) |->
    mem_target_o == host_port_pkg::TGT_IRAM && !mem_we_o) else $error("Page read outside mirror");
  tail_error_a: assert property ((go && tail_hit && !refuse) |=>
    !host_error_out_n_o && !mem_req_o) else $error("Tail read did not raise error");
  hit_served_a: assert property (go_hit |=>
    host_ready_o && host_data_o == $past(buf_data)) else $error("Buffered word not served");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack longer than one cycle");

  hit_c: cover property (go_hit);
  tail_c: cover property (ev_tail);
  prefetch_c: cover property (buf_load);
  net_c: cover property (go_fetch && in_net);
endmodule // host_port_mirror_read

// *** verif/host_mcu_model.sv ***
// Behavioural external processor driving the host port pins
`timescale 1ns/10ps
module host_mcu_model (
  // Clock
  input wire logic clk_i,
  // Answer from the device
  input wire logic ready_i,
  input wire logic error_n_i,
  input wire logic [31:0] rdata_i,
  // Request to the device
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [23:0] addr_o,
  output logic [31:0] wdata_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 24'h0;
    wdata_o = 32'h0;
  end

  // One access, held until ready is sampled high or 40 cycles pass
  task automatic acc(input logic we, input logic [23:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= we;
    wr_n_o <= ~we;
    addr_o <= a;
    wdata_o <= wd;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_i);
      ok = (ready_i === 1'b1);
    end
    d = rdata_i;
    err = (error_n_i === 1'b0);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    // Released lines show no stale value
    addr_o <= ~a;
    wdata_o <= ~wd;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // host_mcu_model

// *** verif/test_host_port_mirror_read.sv ***
// Self-checking bench for host port decode and mirror reading
`timescale 1ns/10ps
`include "host_port_map.svh"
module test_host_port_mirror_read;
  localparam logic [23:0] PH = 24'h0C0000;
  localparam logic [31:0] PI = 32'h40000000;
  localparam logic [23:0] NH = 24'h100000;
  localparam logic [31:0] NI = 32'h50000000;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, host_data_i, host_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic boot_select_high_i, boot_select_low_i, sync_sram_mode_i, chip_select_n_i, host_rd_n_i, host_wr_n_i;
  logic host_data_oe_o, host_ready_o, host_error_out_n_o, mem_req_o, mem_we_o, mem_page_read_o, mem_ack_i;
  logic [23:0] host_addr_i, a;
  host_port_pkg::target_t mem_target_o, l_tgt;
  logic [31:0] l_addr, l_wd, rd, hd, wd;
  logic l_page, l_we, her, hok;
  logic rd_acc = 1'b1;
  logic [1:0] st_exp = 2'h0;
  int num_errors = 0, checked = 0, nreq = 0, wt = 0, cnt = 0, n0;

  host_port_mirror_read #(.PERI_HOST_BASE(PH), .PERI_INT_BASE(PI), .NET_HOST_BASE(NH),
    .NET_SIZE(24'h100000), .NET_INT_BASE(NI)) i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .irq_o, .boot_select_high_i, .boot_select_low_i, .sync_sram_mode_i, .chip_select_n_i, .host_rd_n_i,
    .host_wr_n_i, .host_addr_i, .host_data_i, .host_data_o, .host_data_oe_o, .host_ready_o,
    .host_error_out_n_o, .mem_req_o, .mem_we_o, .mem_target_o, .mem_addr_o, .mem_wdata_o,
    .mem_page_read_o, .mem_rdata_i, .mem_ack_i);

  host_mcu_model i_host (.clk_i(clk_i), .ready_i(host_ready_o), .error_n_i(host_error_out_n_o),
    .rdata_i(host_data_o), .cs_n_o(chip_select_n_i), .rd_n_o(host_rd_n_i), .wr_n_o(host_wr_n_i),
    .addr_o(host_addr_i), .wdata_o(host_data_i));

  function automatic logic [31:0] mem_val(input logic [31:0] x);
    return x ^ 32'hC3A50000;
  endfunction

  // Internal slave with a random wait of 0 to 2 cycles
  wire mem_go = !mem_ack_i && mem_req_o === 1'b1 && cnt == wt;
  always @(posedge clk_i) begin
    mem_ack_i <= mem_go;
    mem_rdata_i <= mem_go ? mem_val(mem_addr_o) : ~mem_rdata_i;
    if (mem_ack_i) begin
      cnt <= 0;
      wt <= $urandom % 3;
    end else if (mem_req_o === 1'b1) begin
      if (cnt == wt) begin
        l_addr <= mem_addr_o;
        l_tgt <= mem_target_o;
        l_page <= mem_page_read_o;
        l_we <= mem_we_o;
        l_wd <= mem_wdata_o;
        nreq <= nreq + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_chk(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, ad, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic hchk(input logic [23:0] ad, input logic e_err, input logic [31:0] e_d);
    i_host.acc(1'b0, ad, 32'h0, hd, her, hok);
    chk({31'h0, hok}, 32'h1);
    chk({31'h0, her}, {31'h0, e_err});
    if (!e_err) chk(hd, e_d);
  endtask

  // Data pins driven while answering a read, never a write
  always @(posedge clk_i) begin
    if (host_ready_o === 1'b1) chk({31'h0, host_data_oe_o}, {31'h0, rd_acc});
  end

  task automatic irq_chk(input logic e);
    @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask

  task automatic setb(input logic h, input logic l, input logic s);
    boot_select_high_i <= h;
    boot_select_low_i <= l;
    sync_sram_mode_i <= s;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, mem_ack_i} = 4'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    mem_rdata_i = 32'h0;
    {boot_select_high_i, boot_select_low_i, sync_sram_mode_i} = 3'b100;
    void'($urandom(32'h49AB));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 4; i++) wb_chk(8'(i * 4), 32'hFFFFFFFF, 32'h0);
    wb_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    wb_chk(`REG_PORT_STATUS, 32'h7, 32'h2);
    wb(1'b1, `REG_BUS_CTRL, 32'hFFFFFFFF);
    wb_chk(`REG_BUS_CTRL, 32'h2, 32'h2);
    wb(1'b1, `REG_BUS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wb(1'b1, `REG_PAGE_CTRL, 32'h2);
      a = (i == 0) ? 24'h0 : 24'($urandom % `MIRROR_TAIL) & 24'hFFFFFC;
      hchk(a, 1'b0, mem_val(`IRAM_INT_BASE + {8'h0, a}));
      chk({30'h0, l_tgt}, {30'h0, host_port_pkg::TGT_IRAM});
      chk({31'h0, l_page}, {31'h0, i > 1});
    end
    wb(1'b1, `REG_PAGE_CTRL, 32'h0);
    a = PH + (24'($urandom % `PERI_SIZE) & 24'hFFFFFC);
    hchk(a, 1'b0, mem_val(PI + {8'h0, a - PH}));
    chk({30'h0, l_tgt}, {30'h0, host_port_pkg::TGT_PERI});
    wd = $urandom;
    rd_acc = 1'b0;
    i_host.acc(1'b1, a, wd, hd, her, hok);
    rd_acc = 1'b1;
    chk({31'h0, hok}, 32'h1);
    chk({31'h0, l_we}, 32'h1);
    chk(l_wd, wd);
    n0 = nreq;
    hchk(NH + 24'h40, 1'b1, 32'h0);
    chk(32'(nreq), 32'(n0));
    st_exp[0] = 1'b1;
    wb_chk(`REG_IRQ_STATUS, 32'h3, {30'h0, st_exp});
    irq_chk(1'b0);
    wb(1'b1, `REG_IRQ_MASK, 32'h3);
    irq_chk(1'b1);
    wb(1'b1, `REG_IRQ_STATUS, 32'h1);
    st_exp = 2'h0;
    irq_chk(1'b0);
    setb(1'b1, 1'b0, 1'b1);
    hchk(NH + 24'h40, 1'b0, mem_val(NI + 32'h40));
    chk({30'h0, l_tgt}, {30'h0, host_port_pkg::TGT_NET});
    setb(1'b0, 1'b1, 1'b1);
    wb_chk(`REG_PORT_STATUS, 32'h7, 32'h5);
    n0 = nreq;
    hchk(24'h000100, 1'b1, 32'h0);
    chk(32'(nreq), 32'(n0));
    irq_chk(1'b1);
    wb(1'b1, `REG_IRQ_STATUS, 32'h1);
    setb(1'b1, 1'b1, 1'b0);
    hchk(24'h000200, 1'b0, mem_val(32'h200));
    setb(1'b1, 1'b0, 1'b0);
    wb(1'b1, `REG_BUS_CTRL, 32'h2);
    a = 24'($urandom % 24'h0BFF00) & 24'hFFFFF0;
    n0 = nreq;
    hchk(a, 1'b0, mem_val({8'h0, a}));
    hchk(a + 24'h4, 1'b0, mem_val({8'h0, a + 24'h4}));
    repeat (10) @(posedge clk_i);
    chk(32'(nreq), 32'(n0 + 3));
    chk(l_addr, {8'h0, a + 24'h8});
    wb_chk(`REG_PORT_STATUS, 32'h1F, 32'h12);
    hchk(`MIRROR_TAIL - 24'h4, 1'b0, mem_val({8'h0, `MIRROR_TAIL - 24'h4}));
    repeat (10) @(posedge clk_i);
    n0 = nreq;
    hchk(`MIRROR_TAIL + 24'(4 * ($urandom % 4)), 1'b1, 32'h0);
    chk(32'(nreq), 32'(n0));
    st_exp[1] = 1'b1;
    wb_chk(`REG_IRQ_STATUS, 32'h3, {30'h0, st_exp});
    irq_chk(1'b1);
    wb(1'b1, `REG_IRQ_STATUS, 32'h2);
    wb(1'b1, `REG_BUS_CTRL, 32'h0);
    n0 = nreq;
    hchk(`MIRROR_TAIL, 1'b0, mem_val({8'h0, `MIRROR_TAIL}));
    repeat (10) @(posedge clk_i);
    chk(32'(nreq), 32'(n0 + 1));
    setb(1'b0, 1'b0, 1'b0);
    i_host.acc(1'b0, 24'h0, 32'h0, hd, her, hok);
    chk({31'h0, hok}, 32'h0);
    stop_test();
  end
endmodule // test_host_port_mirror_read
